// file: hdl/dpse_pkg.sv
package dpse_pkg;

  // ----------------------------------------------------------------
  // Control byte and array geometry
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_CODE   = 4'ha;
  localparam int         MON_AW      = 7;
  localparam int         HOST_AW     = 9;
  localparam int         MON_PG_W    = 3;
  localparam int         HOST_PG_W   = 4;
  localparam logic [3:0] BITS_BYTE   = 4'h8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TWR_NS        = 10_000_000;
  // Longest time, so round down
  localparam int TWR_CYC       = TWR_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Port engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_CTRL  = 3'h1,
    ST_WADDR = 3'h2,
    ST_WDATA = 3'h3,
    ST_RDATA = 3'h4,
    ST_RACK  = 3'h5,
    ST_IGN   = 3'h6
  } dpse_state_t;

endpackage

// file: hdl/dpse_wr_if.sv
// ------------------------------------------------------------------
// Write cycle launch and completion, as toggles
// ------------------------------------------------------------------
interface dpse_wr_if;
  logic req_tgl;
  logic done_tgl;
  modport port  (output req_tgl, input done_tgl);
  modport timer (input req_tgl, output done_tgl);
endinterface

// file: hdl/dpse_sync.sv
module dpse_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ----------------------------------------------------------------
  // Two-stage synchroniser, first stage feeds only the second
  // ----------------------------------------------------------------
  logic [W-1:0] meta;

  if (W < 1) begin : g_chk
    $error("dpse_sync: W must be at least 1");
  end

  always_ff @(posedge clk) begin
    meta <= d;
    q    <= meta;
  end

endmodule

// file: hdl/dpse_wtimer.sv
module dpse_wtimer #(
  parameter int CYCLES = dpse_pkg::TWR_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  dpse_wr_if.timer  wr,
  output logic      busy
);

  // ----------------------------------------------------------------
  // Self-timed programming cycle, system clock domain
  // ----------------------------------------------------------------
  localparam int CW = $clog2(CYCLES + 1);

  logic          req_s;
  logic          req_d;
  logic [CW-1:0] cnt;

  if (CYCLES < 1) begin : g_chk
    $error("dpse_wtimer: CYCLES must be at least 1");
  end

  dpse_sync #(.W(1)) u_req_sync (
    .clk (clk),
    .d   (wr.req_tgl),
    .q   (req_s)
  );

  wire launch = req_s ^ req_d;
  wire last   = busy && (cnt == CW'(1));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_d       <= 1'b0;
      cnt         <= '0;
      busy        <= 1'b0;
      wr.done_tgl <= 1'b0;
    end else begin
      req_d <= req_s;
      if (launch) begin
        busy <= 1'b1;
        cnt  <= CW'(CYCLES);
      end else if (busy) begin
        cnt <= cnt - CW'(1);
        if (last) begin
          busy        <= 1'b0;
          wr.done_tgl <= ~wr.done_tgl;
        end
      end
    end
  end

endmodule

// file: hdl/dpse_top.sv
module dpse_top #(
  parameter int WR_CYCLES = dpse_pkg::TWR_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic link_clk,
  input  wire logic monitor_bidir_clock,
  input  wire logic monitor_data_line_in,
  output logic      monitor_data_line_out,
  output logic      monitor_data_line_oe,
  input  wire logic monitor_stream_clock_write_guard,
  input  wire logic host_port_clock,
  input  wire logic host_port_data_line_in,
  output logic      host_port_data_line_out,
  output logic      host_port_data_line_oe,
  input  wire logic host_port_write_guard,
  output logic      monitor_bidir_mode,
  output logic      monitor_write_busy,
  output logic      host_write_busy
);

  // ----------------------------------------------------------------
  // Pin and control synchronisers into the link domain
  // ----------------------------------------------------------------
  logic [5:0] pin_s;
  logic [2:0] ctl_s;
  logic [1:0] done_raw;
  logic [1:0] busy_clk;
  logic [1:0] oe_vec;
  logic       link_rst_n;
  logic       mon_scl_d;

  if (WR_CYCLES < 1) begin : g_chk
    $error("dpse_top: WR_CYCLES must be at least 1");
  end

  dpse_sync #(.W(6)) u_pin_sync (
    .clk (link_clk),
    .d   ({host_port_write_guard, monitor_stream_clock_write_guard,
           host_port_data_line_in, monitor_data_line_in,
           host_port_clock, monitor_bidir_clock}),
    .q   (pin_s)
  );

  // Reset reaches the link domain late; link clock runs free
  dpse_sync #(.W(3)) u_ctl_sync (
    .clk (link_clk),
    .d   ({done_raw, rst_n}),
    .q   (ctl_s)
  );

  assign link_rst_n = ctl_s[0];

  // ----------------------------------------------------------------
  // Monitor mode switch
  // ----------------------------------------------------------------
  wire mon_scl_fall = mon_scl_d & ~pin_s[0];

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      mon_scl_d          <= 1'b1;
      monitor_bidir_mode <= 1'b0;
    end else begin
      mon_scl_d <= pin_s[0];
      // No path back; only power-on reset leaves it
      if (mon_scl_fall)
        monitor_bidir_mode <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Open-drain data outputs: only ever pull low; busy flags come from the timers
  // ----------------------------------------------------------------
  assign monitor_data_line_out   = 1'b0;
  assign host_port_data_line_out = 1'b0;
  assign monitor_data_line_oe    = oe_vec[0];
  assign host_port_data_line_oe  = oe_vec[1];
  assign monitor_write_busy      = busy_clk[0];
  assign host_write_busy         = busy_clk[1];

  // ----------------------------------------------------------------
  // Port engines, index 0 monitor, index 1 host
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_port
    localparam int AW  = (i == 0) ? dpse_pkg::MON_AW : dpse_pkg::HOST_AW;
    localparam int PGW = (i == 0) ? dpse_pkg::MON_PG_W
                                  : dpse_pkg::HOST_PG_W;
    localparam int PG  = 1 << PGW;

    dpse_wr_if wif ();

    dpse_wtimer #(.CYCLES(WR_CYCLES)) u_timer (
      .clk  (clk),
      .rst_n(rst_n),
      .wr   (wif.timer),
      .busy (busy_clk[i])
    );

    assign done_raw[i] = wif.done_tgl;

    logic [7:0]          mem [1 << AW];
    logic [7:0]          pbuf [PG];
    logic [PG-1:0]       pvalid;
    dpse_pkg::dpse_state_t st;
    dpse_pkg::dpse_state_t next_st;
    logic [3:0]          bitc;
    logic [3:0]          next_bitc;
    logic [7:0]          shreg;
    logic [7:0]          next_shreg;
    logic [AW-1:0]       ptr;
    logic [AW-1:0]       next_ptr;
    logic                in_ack;
    logic                next_in_ack;
    logic                oe;
    logic                next_oe;
    logic                rw;
    logic                next_rw;
    logic                blk;
    logic                next_blk;
    logic                gbad;
    logic                next_gbad;
    logic                hdat;
    logic                next_hdat;
    logic                scl_d;
    logic                sda_d;
    logic                req;

    // Synchronised pins and edges
    wire scl = pin_s[i];
    wire sda = pin_s[2 + i];
    wire grd = pin_s[4 + i];
    wire scl_rise = scl & ~scl_d;
    wire scl_fall = ~scl & scl_d;
    wire start = scl & scl_d & sda_d & ~sda;
    wire stop  = scl & scl_d & ~sda_d & sda;

    // Monitor engine silent until two-way mode
    wire port_en = (i == 0) ? monitor_bidir_mode : 1'b1;
    // Guard sense differs per port
    wire wp_block = (i == 0) ? ~grd : grd;
    wire busy_l = req ^ ctl_s[1 + i];

    // Decoding
    wire byte_done = scl_fall & ~in_ack & (bitc == dpse_pkg::BITS_BYTE);
    wire ack_end   = scl_fall & in_ack;
    wire type_ok   = shreg[7:4] == dpse_pkg::CTRL_CODE;
    wire ctrl_ok   = type_ok & ~busy_l & port_en;
    wire [8:0] full_addr = {blk, shreg};
    wire [AW-1:0] addr_load = full_addr[AW-1:0];
    wire [PGW-1:0] off = ptr[PGW-1:0];
    wire [PGW-1:0] off_inc = off + PGW'(1);
    wire [AW-1:0] ptr_page = {ptr[AW-1:PGW], off_inc};
    wire [AW-1:0] ptr_inc = ptr + AW'(1);
    wire [7:0] rd_byte = mem[ptr];
    wire in_wr = (st == dpse_pkg::ST_WADDR) | (st == dpse_pkg::ST_WDATA);
    wire buf_we = byte_done & (st == dpse_pkg::ST_WDATA) & ~start & ~stop;
    // Guarded writes still ack, only the commit is dropped
    wire commit = stop & (st == dpse_pkg::ST_WDATA) & hdat & ~gbad
                & ~busy_l & port_en;

    always_comb begin
      next_st     = st;
      next_bitc   = bitc;
      next_shreg  = shreg;
      next_ptr    = ptr;
      next_in_ack = in_ack;
      next_oe     = oe;
      next_rw     = rw;
      next_blk    = blk;
      next_gbad   = gbad;
      next_hdat   = hdat;
      if (start) begin
        next_st     = dpse_pkg::ST_CTRL;
        next_bitc   = 4'h0;
        next_in_ack = 1'b0;
        next_oe     = 1'b0;
        next_gbad   = 1'b0;
        next_hdat   = 1'b0;
      end else if (stop) begin
        next_st     = dpse_pkg::ST_IDLE;
        next_in_ack = 1'b0;
        next_oe     = 1'b0;
      end else begin
        if (wp_block && in_wr)
          next_gbad = 1'b1;
        unique case (st)
          dpse_pkg::ST_CTRL, dpse_pkg::ST_WADDR, dpse_pkg::ST_WDATA: begin
            if (scl_rise && !in_ack) begin
              next_shreg = {shreg[6:0], sda};
              next_bitc  = bitc + 4'h1;
            end else if (byte_done) begin
              next_in_ack = 1'b1;
              next_oe     = port_en;
              if (st == dpse_pkg::ST_CTRL) begin
                next_rw  = shreg[0];
                next_blk = shreg[1];
                if (!ctrl_ok) begin
                  next_st     = dpse_pkg::ST_IGN;
                  next_oe     = 1'b0;
                  next_in_ack = 1'b0;
                end
              end else if (st == dpse_pkg::ST_WADDR) begin
                next_ptr  = addr_load;
                next_hdat = 1'b0;
              end else begin
                next_ptr  = ptr_page;
                next_hdat = 1'b1;
              end
            end else if (ack_end) begin
              next_in_ack = 1'b0;
              next_oe     = 1'b0;
              next_bitc   = 4'h0;
              if (st == dpse_pkg::ST_CTRL && rw) begin
                next_st    = dpse_pkg::ST_RDATA;
                next_shreg = rd_byte;
                next_ptr   = ptr_inc;
                next_oe    = ~rd_byte[7];
              end else if (st == dpse_pkg::ST_CTRL) begin
                next_st = dpse_pkg::ST_WADDR;
              end else begin
                next_st = dpse_pkg::ST_WDATA;
              end
            end
          end
          dpse_pkg::ST_RDATA: begin
            if (scl_rise) begin
              next_bitc = bitc + 4'h1;
            end else if (scl_fall &&
                         bitc == dpse_pkg::BITS_BYTE) begin
              next_st   = dpse_pkg::ST_RACK;
              next_oe   = 1'b0;
              next_bitc = 4'h0;
            end else if (scl_fall) begin
              next_shreg = {shreg[6:0], 1'b0};
              next_oe    = ~shreg[6];
            end
          end
          dpse_pkg::ST_RACK: begin
            if (scl_rise && sda) begin
              next_st = dpse_pkg::ST_IGN;
            end else if (scl_fall) begin
              next_st    = dpse_pkg::ST_RDATA;
              next_shreg = rd_byte;
              next_ptr   = ptr_inc;
              next_oe    = ~rd_byte[7];
            end
          end
          dpse_pkg::ST_IDLE, dpse_pkg::ST_IGN: begin
            next_st = st;
          end
          default: begin
            next_st = dpse_pkg::ST_IDLE;
          end
        endcase
      end
    end

    always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
        st     <= dpse_pkg::ST_IDLE;
        bitc   <= 4'h0;
        shreg  <= 8'h00;
        ptr    <= '0;
        in_ack <= 1'b0;
        oe     <= 1'b0;
        rw     <= 1'b0;
        blk    <= 1'b0;
        gbad   <= 1'b0;
        hdat   <= 1'b0;
        scl_d  <= 1'b1;
        sda_d  <= 1'b1;
      end else begin
        st     <= next_st;
        bitc   <= next_bitc;
        shreg  <= next_shreg;
        ptr    <= next_ptr;
        in_ack <= next_in_ack;
        oe     <= next_oe;
        rw     <= next_rw;
        blk    <= next_blk;
        gbad   <= next_gbad;
        hdat   <= next_hdat;
        scl_d  <= scl;
        sda_d  <= sda;
      end
    end

    // Page buffer: wraps on its own offset, so late bytes replace early
    always_ff @(posedge link_clk) begin
      if (!link_rst_n || start) begin
        pvalid <= '0;
      end else if (buf_we) begin
        pbuf[off]   <= shreg;
        pvalid[off] <= 1'b1;
      end
    end

    // Array is updated at STOP; timer then holds off acks
    always_ff @(posedge link_clk) begin
      if (commit) begin
        for (int j = 0; j < PG; j++) begin
          if (pvalid[j])
            mem[{ptr[AW-1:PGW], PGW'(j)}] <= pbuf[j];
        end
      end
    end

    always_ff @(posedge link_clk) begin
      if (!link_rst_n)
        req <= 1'b0;
      else if (commit)
        req <= ~req;
    end

    assign wif.req_tgl = req;
    assign oe_vec[i]   = oe;
  end

endmodule

// file: tb/dpse_top_assertions.sv
module dpse_top_chk #(
  parameter int WR_CYCLES = 50
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic monitor_bidir_clock,
  input wire logic monitor_data_line_out,
  input wire logic monitor_data_line_oe,
  input wire logic monitor_stream_clock_write_guard,
  input wire logic host_port_clock,
  input wire logic host_port_data_line_out,
  input wire logic host_port_data_line_oe,
  input wire logic host_port_write_guard,
  input wire logic monitor_bidir_mode,
  input wire logic monitor_write_busy,
  input wire logic host_write_busy
);
  int hcnt;

  always_ff @(posedge clk) hcnt <= host_write_busy ? hcnt + 1 : 0;

  AST_OUT_LOW: assert property (
    @(posedge link_clk) disable iff (!rst_n)
    !monitor_data_line_out && !host_port_data_line_out)
    else $error("open-drain output driven high");
  AST_MODE_STICKY: assert property (
    @(posedge link_clk) disable iff (!rst_n)
    monitor_bidir_mode |=> monitor_bidir_mode)
    else $error("two-way mode lost");
  AST_MODE_CAUSE: assert property (
    @(posedge link_clk) disable iff (!rst_n)
    (monitor_bidir_clock && !monitor_bidir_mode) [*6] |=> !monitor_bidir_mode)
    else $error("mode entered without clock fall");
  AST_MON_QUIET: assert property (
    @(posedge link_clk) disable iff (!rst_n)
    !monitor_bidir_mode |-> !monitor_data_line_oe)
    else $error("monitor drives line before mode");
  AST_MON_BUSY: assert property (
    @(posedge clk) disable iff (!rst_n)
    monitor_write_busy |-> !monitor_data_line_oe)
    else $error("monitor drives line while busy");
  AST_HOST_BUSY: assert property (
    @(posedge clk) disable iff (!rst_n)
    host_write_busy |-> !host_port_data_line_oe)
    else $error("host drives line while busy");
  AST_HOST_GUARD: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(host_write_busy) |-> !$past(host_port_write_guard, 6))
    else $error("host programs with guard high");
  AST_MON_GUARD: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(monitor_write_busy) |-> $past(monitor_stream_clock_write_guard, 6))
    else $error("monitor programs with guard low");
  AST_BUSY_LEN: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(host_write_busy) |-> hcnt >= WR_CYCLES - 1 && hcnt <= WR_CYCLES + 1)
    else $error("host write cycle length wrong");
  // Oe may only move after a clock fall, never in the high phase
  AST_HOST_STABLE: assert property (
    @(posedge link_clk) disable iff (!rst_n)
    host_port_clock && $past(host_port_clock)
      |-> $stable(host_port_data_line_oe))
    else $error("host line moved while clock high");
  AST_MON_STABLE: assert property (
    @(posedge link_clk) disable iff (!rst_n)
    monitor_bidir_clock && $past(monitor_bidir_clock)
      |-> $stable(monitor_data_line_oe))
    else $error("monitor line moved while clock high");
endmodule

bind dpse_top dpse_top_chk #(.WR_CYCLES(WR_CYCLES)) u_chk (
  .clk(clk), .rst_n(rst_n), .link_clk(link_clk),
  .monitor_bidir_clock(monitor_bidir_clock),
  .monitor_data_line_out(monitor_data_line_out),
  .monitor_data_line_oe(monitor_data_line_oe),
  .monitor_stream_clock_write_guard(monitor_stream_clock_write_guard),
  .host_port_clock(host_port_clock),
  .host_port_data_line_out(host_port_data_line_out),
  .host_port_data_line_oe(host_port_data_line_oe),
  .host_port_write_guard(host_port_write_guard),
  .monitor_bidir_mode(monitor_bidir_mode),
  .monitor_write_busy(monitor_write_busy),
  .host_write_busy(host_write_busy)
);

// file: tb/dpse_master.sv
module dpse_master (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  // Clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic hp();
    repeat (12) @(posedge clk);
  endtask
  task automatic start();
    sda_oe <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    sda_oe <= 1'b1;
    hp();
    scl <= 1'b0;
  endtask
  task automatic stop();
    sda_oe <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sda_oe <= 1'b0;
    hp();
  endtask
  task automatic bitx(input logic b, output logic r);
    hp();
    sda_oe <= ~b;
    hp();
    scl <= 1'b1;
    hp();
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(last, r);
  endtask
endmodule

// file: tb/dpse_top_bench.sv
module dpse_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WR = 500;
  logic        clk, link_clk, rst_n, m_grd, h_grd, mode, m_busy, h_busy;
  logic        m_scl, m_moe, m_out, m_oe, h_scl, h_moe, h_out, h_oe;
  logic [7:0]  hmem [512];
  logic [7:0]  mmem [128];
  logic [7:0]  exp_q [$];
  logic [7:0]  res;
  logic [15:0] lf;
  int          error_cnt, checks_done;
  event        res_ev;
  // Pulled-up wires: a released line reads high
  wire m_sda = ~(m_moe | (m_oe & ~m_out));
  wire h_sda = ~(h_moe | (h_oe & ~h_out));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #3.2;
    forever #7.5 link_clk = ~link_clk;
  end

  dpse_top #(.WR_CYCLES(WR)) dut (
    .clk(clk), .rst_n(rst_n), .link_clk(link_clk),
    .monitor_bidir_clock(m_scl), .monitor_data_line_in(m_sda),
    .monitor_data_line_out(m_out), .monitor_data_line_oe(m_oe),
    .monitor_stream_clock_write_guard(m_grd),
    .host_port_clock(h_scl), .host_port_data_line_in(h_sda),
    .host_port_data_line_out(h_out), .host_port_data_line_oe(h_oe),
    .host_port_write_guard(h_grd), .monitor_bidir_mode(mode),
    .monitor_write_busy(m_busy), .host_write_busy(h_busy));
  dpse_master u_mon (.clk(clk), .sda(m_sda), .scl(m_scl), .sda_oe(m_moe));
  dpse_master u_host (.clk(clk), .sda(h_sda), .scl(h_scl), .sda_oe(h_moe));

  initial begin
    logic [7:0] e;
    forever begin
      @(res_ev);
      e = exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx;
      checks_done++;
      if (res !== e) begin
        error_cnt++;
        $display("[ERR] %0t exp %h got %h", $time, e, res);
      end
    end
  end

  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic print_verdict();
    if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    exp_q.push_back(e);
    res = g;
    ->res_ev;
  endtask
  task automatic st(input bit p);
    if (p) u_host.start();
    else u_mon.start();
  endtask
  task automatic sp(input bit p);
    if (p) u_host.stop();
    else u_mon.stop();
  endtask
  task automatic tx(input bit p, input logic [7:0] d, input logic e);
    logic a;
    if (p) u_host.wbyte(d, a);
    else u_mon.wbyte(d, a);
    chk({7'h0, e}, {7'h0, a});
  endtask
  task automatic rx(input bit p, input logic l, input logic [7:0] e);
    logic [7:0] d;
    if (p) u_host.rbyte(l, d);
    else u_mon.rbyte(l, d);
    chk(e, d);
  endtask
  task automatic bz(input bit p, input bit ok);
    logic b;
    b = 1'b0;
    repeat (20) begin
      @(posedge clk);
      if ((p ? h_busy : m_busy) === 1'b1) b = 1'b1;
    end
    chk({7'h0, ok}, {7'h0, b});
    if (ok) begin
      st(p);
      tx(p, 8'ha0, 1'b0);
      sp(p);
    end
    if (p) begin
      st(0);
      tx(0, 8'ha0, 1'b1);
      sp(0);
    end
    for (int k = 0; (p ? h_busy : m_busy) !== 1'b0; k++) begin
      if (k == 2 * WR) begin
        error_cnt++;
        print_verdict();
      end
      @(posedge clk);
    end
  endtask
  task automatic wr(input bit p, input logic [2:0] blk, input logic [7:0] a,
                    input int n, input bit ok);
    logic [8:0] ad;
    logic [7:0] d;
    st(p);
    tx(p, {4'ha, blk, 1'b0}, 1'b1);
    tx(p, a, 1'b1);
    for (int i = 0; i < n; i++) begin
      lf = nx(lf);
      d = lf[7:0];
      tx(p, d, 1'b1);
      if (p) ad = {blk[0], a[7:4], a[3:0] + 4'(i)};
      else ad = {2'b00, a[6:3], a[2:0] + 3'(i)};
      if (ok && p) hmem[ad] = d;
      if (ok && !p) mmem[ad[6:0]] = d;
    end
    sp(p);
    bz(p, ok);
  endtask
  task automatic rd(input bit p, input logic [2:0] blk, input logic [7:0] a,
                    input int n);
    logic [8:0] ad;
    st(p);
    tx(p, {4'ha, blk, 1'b0}, 1'b1);
    tx(p, a, 1'b1);
    st(p);
    tx(p, {4'ha, blk, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      ad = p ? {blk[0], a} + 9'(i) : {2'b00, a[6:0] + 7'(i)};
      rx(p, i == n - 1, p ? hmem[ad] : mmem[ad[6:0]]);
    end
    sp(p);
  endtask

  initial begin
    rst_n = 1'b0;
    m_grd = 1'b1;
    h_grd = 1'b0;
    lf = 16'h51f8;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk(8'h00, {7'h0, mode});
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 16; c++) begin
        lf = nx(lf);
        st(p[0]);
        tx(p[0], {4'(c), lf[2:0], 1'b0}, c == 10);
        sp(p[0]);
      end
    end
    chk(8'h01, {7'h0, mode});
    wr(1, 3'b101, 8'h3e, 17, 1);
    rd(1, 3'b011, 8'h30, 15);
    st(1);
    tx(1, 8'ha3, 1'b1);
    rx(1, 1'b1, hmem[9'h13f]);
    sp(1);
    h_grd <= 1'b1;
    wr(1, 3'b001, 8'h30, 1, 0);
    h_grd <= 1'b0;
    wr(1, 3'b000, 8'h30, 1, 1);
    rd(1, 3'b001, 8'h30, 1);
    rd(1, 3'b000, 8'h30, 1);
    wr(0, lf[2:0], 8'h85, 9, 1);
    rd(0, lf[5:3], 8'h00, 8);
    m_grd <= 1'b0;
    wr(0, 3'b111, 8'h02, 1, 0);
    m_grd <= 1'b1;
    rd(0, 3'b000, 8'h02, 1);
    print_verdict();
  end
endmodule
